// File: include/ets_pkg.sv
// constants and types shared by the exposure trigger strobe control block
package ets_pkg;
  localparam int          AXI_AW          = 4;
  localparam logic [3:0]  ADDR_CONFIG     = 4'h0;
  localparam logic [3:0]  ADDR_SHUTTER    = 4'h4;
  localparam logic [3:0]  ADDR_STATUS     = 4'h8;
  // config register fields
  localparam int          CFG_ASYNC_BIT   = 0;
  localparam int          CFG_PWC_BIT     = 1;
  localparam int          CFG_LINK_INV    = 2;
  localparam int          CFG_SEL_LO_BIT  = 5;
  localparam int          CFG_SEL_HI_BIT  = 6;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
  // shutter register fields
  localparam int          SHUT_SEL_LSB    = 0;
  localparam int          SHUT_PRE_LSB    = 8;
  localparam logic [3:0]  SHUT_SEL_RESET  = 4'h0;
  localparam logic [15:0] PRESET_RESET    = 16'h0001;
  localparam logic [3:0]  SHUT_NONE       = 4'h0;
  localparam logic [3:0]  SHUT_PWC_POS    = 4'h9;
  // status register fields
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_EXP_BIT    = 1;
  localparam int          STAT_MEAS_LSB   = 16;
  // exposure line counts
  localparam logic [15:0] LINES_ONE       = 16'h0001;
  localparam logic [15:0] LINES_ZERO      = 16'h0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_PWC_EXP,
    ST_PRE_EXP,
    ST_WAIT_RD
  } ets_state_t;
endpackage : ets_pkg

// File: hdl/ets_trig_cond.sv
// trigger polarity, combining and edge detection, plus line sync edge
`timescale 1ns/1ps
module ets_trig_cond (
  // clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RESET_N,
  // raw inputs
  input  wire logic conn_trig_n,
  input  wire logic link_trig,
  input  wire logic link_inv,
  input  wire logic line_sync_n,
  // conditioned outputs
  output logic      trig_active,
  output logic      trig_lead,
  output logic      trig_trail,
  output logic      line_tick
);
  import ets_pkg::*;

  typedef struct packed {
    logic trig;
    logic line;
  } ets_tc_t;

  ets_tc_t s_r;
  ets_tc_t s_nxt;
  logic    link_active;

  // connector side is always active low; only the link side may invert
  assign link_active = link_inv ? link_trig : ~link_trig;
  assign trig_active = ~conn_trig_n | link_active;
  assign trig_lead   = trig_active & ~s_r.trig;
  assign trig_trail  = ~trig_active & s_r.trig;
  // trailing edge of the active-low line sync pulse
  assign line_tick   = line_sync_n & ~s_r.line;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.trig = trig_active;
    s_nxt.line = line_sync_n;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r <= '{trig: 1'b0, line: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  a_conn_active : assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    !conn_trig_n |-> trig_active)
    else $error("connector trigger low not seen as active");
endmodule : ets_trig_cond

// File: hdl/ets_ctrl.sv
// exposure trigger and strobe control with an AXI4-Lite register slave
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module ets_ctrl (
  // clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESET_N,
  // axi4-lite write address and data
  input  wire logic [ets_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]                  S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [ets_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  // trigger inputs
  input  wire logic                   CONNECTOR_TRIGGER_IN_N,
  input  wire logic                   LINK_TRIGGER_IN,
  // sensor timing
  input  wire logic                   INTERNAL_LINE_SYNC_N,
  input  wire logic                   FRAME_START,
  input  wire logic                   READOUT_DONE,
  // sensor control and strobe terminal
  output logic                        EXPOSURE_GATE,
  output logic                        READOUT_START,
  output logic                        STROBE_TIMING_OUT
);
  import ets_pkg::*;

  typedef struct packed {
    ets_state_t  st;
    logic [15:0] cnt;
    logic [15:0] remain;
    logic [15:0] meas;
    logic        exp;
    logic        rd_start;
    logic        strobe;
    logic [31:0] cfg;
    logic [3:0]  shut_sel;
    logic [15:0] preset;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ets_ctrl_t;

  ets_ctrl_t   s_r;
  ets_ctrl_t   s_nxt;
  logic        trig_active;
  logic        trig_lead;
  logic        trig_trail;
  logic        line_tick;
  logic        async_en;
  logic        pwc_mode;
  logic        no_shutter;
  logic        busy;
  logic [31:0] wmask;
  logic [31:0] shut_word;
  logic [31:0] stat_word;
  logic [31:0] shut_merge;

  ets_trig_cond u_trig (
    .CORE_CLK    (CORE_CLK),
    .RESET_N     (RESET_N),
    .conn_trig_n (CONNECTOR_TRIGGER_IN_N),
    .link_trig   (LINK_TRIGGER_IN),
    .link_inv    (s_r.cfg[CFG_LINK_INV]),
    .line_sync_n (INTERNAL_LINE_SYNC_N),
    .trig_active (trig_active),
    .trig_lead   (trig_lead),
    .trig_trail  (trig_trail),
    .line_tick   (line_tick)
  );

  // byte lane mask from the write strobes
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign wmask[gl*8 +: 8] = {8{s_r.wstrb[gl]}};
    end
  endgenerate

  assign async_en   = s_r.cfg[CFG_ASYNC_BIT];
  assign no_shutter = (s_r.shut_sel == SHUT_NONE);
  assign pwc_mode   = s_r.cfg[CFG_PWC_BIT]
                      && (s_r.shut_sel == SHUT_PWC_POS);
  // busy only has meaning for triggered frames
  assign busy       = async_en && (s_r.st != ST_IDLE);
  assign shut_word  = {8'h00, s_r.preset, 4'h0, s_r.shut_sel};
  assign stat_word  = {s_r.meas, 14'h0000, s_r.exp, busy};
  assign shut_merge = (shut_word & ~wmask) | (s_r.wdata & wmask);

  assign S_AXI_AWREADY     = !s_r.aw_got && !s_r.bvalid;
  assign S_AXI_WREADY      = !s_r.w_got && !s_r.bvalid;
  assign S_AXI_ARREADY     = !s_r.rvalid;
  assign S_AXI_BVALID      = s_r.bvalid;
  assign S_AXI_BRESP       = s_r.bresp;
  assign S_AXI_RVALID      = s_r.rvalid;
  assign S_AXI_RDATA       = s_r.rdata;
  assign S_AXI_RRESP       = s_r.rresp;
  assign EXPOSURE_GATE     = s_r.exp;
  assign READOUT_START     = s_r.rd_start;
  assign STROBE_TIMING_OUT = s_r.strobe;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.rd_start = 1'b0;

    // write channel: address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = S_AXI_WDATA;
      s_nxt.wstrb = S_AXI_WSTRB;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      if (s_r.awaddr == ADDR_CONFIG) begin
        s_nxt.cfg = (s_r.cfg & ~wmask) | (s_r.wdata & wmask);
      end else if (s_r.awaddr == ADDR_SHUTTER) begin
        s_nxt.shut_sel = shut_merge[SHUT_SEL_LSB +: 4];
        s_nxt.preset   = shut_merge[SHUT_PRE_LSB +: 16];
      end else if (s_r.awaddr == ADDR_STATUS) begin
        s_nxt.bresp = RESP_OKAY;
      end else begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end

    // read channel: answer one cycle after the address is taken
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      if (S_AXI_ARADDR == ADDR_CONFIG) begin
        s_nxt.rdata = s_r.cfg;
      end else if (S_AXI_ARADDR == ADDR_SHUTTER) begin
        s_nxt.rdata = shut_word;
      end else if (S_AXI_ARADDR == ADDR_STATUS) begin
        s_nxt.rdata = stat_word;
      end else begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = RESP_SLVERR;
      end
    end else if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end

    // exposure sequencing
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.exp = 1'b0;
        if (no_shutter) begin
          // continuous image output, sensor always integrating
          s_nxt.exp = 1'b1;
        end else if (async_en && pwc_mode && trig_lead) begin
          s_nxt.st  = ST_ARM;
          s_nxt.cnt = LINES_ZERO;
        end else if (async_en && !pwc_mode && trig_trail) begin
          s_nxt.st     = ST_PRE_EXP;
          s_nxt.exp    = 1'b1;
          s_nxt.remain = s_r.preset;
        end else if (!async_en && FRAME_START) begin
          s_nxt.st     = ST_PRE_EXP;
          s_nxt.exp    = 1'b1;
          s_nxt.remain = s_r.preset;
        end
      end
      ST_ARM: begin
        // wait for the first line sample; a pulse under one line still
        // exposes one line so that n never drops below one
        if (line_tick) begin
          s_nxt.st  = ST_PWC_EXP;
          s_nxt.exp = 1'b1;
          s_nxt.cnt = LINES_ONE;
        end
      end
      ST_PWC_EXP: begin
        if (line_tick) begin
          if (trig_active) begin
            s_nxt.cnt = s_r.cnt + LINES_ONE;
          end else begin
            // close on the first sample that sees the trigger released
            s_nxt.st       = ST_WAIT_RD;
            s_nxt.exp      = 1'b0;
            s_nxt.meas     = s_r.cnt;
            s_nxt.rd_start = 1'b1;
          end
        end
      end
      ST_PRE_EXP: begin
        // trigger level is not looked at here
        if (line_tick) begin
          if (s_r.remain <= LINES_ONE) begin
            s_nxt.st       = ST_WAIT_RD;
            s_nxt.exp      = 1'b0;
            s_nxt.remain   = LINES_ZERO;
            s_nxt.rd_start = 1'b1;
          end else begin
            s_nxt.remain = s_r.remain - LINES_ONE;
          end
        end
      end
      ST_WAIT_RD: begin
        // new triggers are dropped until the frame has been read out
        if (READOUT_DONE) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st  = ST_IDLE;
        s_nxt.exp = 1'b0;
      end
    endcase

    // shared output terminal, registered so it is glitch free
    if (s_r.cfg[CFG_SEL_HI_BIT] == 1'b0 && s_r.cfg[CFG_SEL_LO_BIT]) begin
      s_nxt.strobe = s_nxt.exp;
    end else if (s_r.cfg[CFG_SEL_HI_BIT] && !s_r.cfg[CFG_SEL_LO_BIT]) begin
      s_nxt.strobe = async_en && (s_nxt.st != ST_IDLE);
    end else begin
      s_nxt.strobe = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r          <= '0;
      s_r.st       <= ST_IDLE;
      s_r.cfg      <= CFG_RESET;
      s_r.shut_sel <= SHUT_SEL_RESET;
      s_r.preset   <= PRESET_RESET;
      s_r.strobe   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_preset_go;
    s_r.st == ST_IDLE && async_en && !pwc_mode && !no_shutter && trig_trail;
  endsequence

  sequence s_pwc_step;
    s_r.st == ST_PWC_EXP && line_tick && trig_active;
  endsequence

  a_preset_start : assert property (
    s_preset_go |=> s_r.st == ST_PRE_EXP && EXPOSURE_GATE)
    else $error("preset exposure did not start on trigger trailing edge");

  a_preset_fixed : assert property (
    s_r.st == ST_PRE_EXP && !line_tick |=> $stable(s_r.remain))
    else $error("preset exposure length moved without a line tick");

  a_pwc_arm : assert property (
    s_r.st == ST_IDLE && async_en && pwc_mode && !no_shutter && trig_lead
    |=> s_r.st == ST_ARM)
    else $error("pulse width mode not armed by trigger");

  a_pwc_count : assert property (
    s_pwc_step |=> s_r.cnt == $past(s_r.cnt) + LINES_ONE)
    else $error("line count did not advance while trigger low");

  a_pwc_close : assert property (
    s_r.st == ST_PWC_EXP && line_tick && !trig_active
    |=> READOUT_START && !EXPOSURE_GATE && s_r.meas >= LINES_ONE)
    else $error("pulse width exposure did not close correctly");

  a_no_shutter : assert property (
    s_r.st == ST_IDLE && no_shutter |=> EXPOSURE_GATE)
    else $error("selector zero did not give continuous exposure");

  a_strobe_high : assert property (
    !s_r.cfg[CFG_SEL_HI_BIT] && !s_r.cfg[CFG_SEL_LO_BIT]
    |=> STROBE_TIMING_OUT)
    else $error("strobe terminal not held high in off setting");

  a_strobe_exp : assert property (
    !s_r.cfg[CFG_SEL_HI_BIT] && s_r.cfg[CFG_SEL_LO_BIT]
    |=> STROBE_TIMING_OUT == EXPOSURE_GATE)
    else $error("strobe output differs from exposure gate");

  a_busy_hold : assert property (
    s_r.st == ST_WAIT_RD && !READOUT_DONE |=> s_r.st == ST_WAIT_RD)
    else $error("busy state left before readout completed");
endmodule : ets_ctrl

// File: verification/ets_trig_src.sv
// trigger source model standing in for the capture board or user unit
`timescale 1ns/1ps
module ets_trig_src #(
  parameter int LINE = 24
) (
  // clock
  input  wire logic       CORE_CLK,
  // pulse request from the bench
  input  wire logic       go,
  input  wire logic       use_link,
  input  wire logic       link_inv,
  input  wire logic [5:0] lines,
  // trigger pins
  output logic            conn_n,
  output logic            link
);
  int   left = 0;
  logic act;

  assign act = left > 0;
  // unused side rests inactive so the combined trigger can end
  assign conn_n = !(act && !use_link);
  assign link   = (act && use_link) ^ !link_inv;

  // one clean pulse of whole lines, no chatter
  always @(posedge CORE_CLK) begin
    if (go && left == 0)
      left <= int'(lines) * LINE;
    else if (left > 0)
      left <= left - 1;
  end
endmodule : ets_trig_src

// File: verification/ets_ctrl_tb.sv
// self-checking bench for the exposure trigger strobe control block
`timescale 1ns/1ps
module ets_ctrl_tb;
  import ets_pkg::*;
  localparam int LINE = 24;
  logic              core_clk = 1'b0, reset_n = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = 4'hf;
  logic [1:0]        bresp, rresp;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              conn_n, link, gate, rd_start, strobe;
  logic              line_n = 1'b1, line_q = 1'b1, gate_q = 1'b0;
  logic              frame_start = 1'b0, rd_done = 1'b0;
  logic              go = 1'b0, use_link = 1'b0, inv = 1'b0;
  logic [5:0]        lines = 6'h1;
  logic [15:0]       ticks = '0;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [15:0]       eq[$];
  int                lc = 0, rd_dly = 4, rd_cnt = 0, smode = 2;
  int                mismatches = 0, total_checks = 0;

  always #2.5 core_clk = ~core_clk;

  ets_ctrl i_dut (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CONNECTOR_TRIGGER_IN_N(conn_n), .LINK_TRIGGER_IN(link),
    .INTERNAL_LINE_SYNC_N(line_n), .FRAME_START(frame_start),
    .READOUT_DONE(rd_done), .EXPOSURE_GATE(gate),
    .READOUT_START(rd_start), .STROBE_TIMING_OUT(strobe));

  ets_trig_src #(.LINE(LINE)) i_src (.CORE_CLK(core_clk), .go(go),
    .use_link(use_link), .link_inv(inv), .lines(lines), .conn_n(conn_n),
    .link(link));

  // line sync: two low cycles per line, rising edge is the sample point
  always @(posedge core_clk) begin
    lc <= (lc == LINE - 1) ? 0 : lc + 1;
    line_n <= (lc >= 2);
    rd_done <= (rd_cnt == 1);
    if (rd_start)
      rd_cnt <= rd_dly;
    else if (rd_cnt > 0)
      rd_cnt <= rd_cnt - 1;
  end

  task automatic chk_bus(input string s, input logic [33:0] e,
                         input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk_bus

  task automatic chk_pin(input string s, input logic [15:0] e,
                         input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk_pin

  // result watcher: exposure length in line ticks, bus answers, strobe pin
  always @(posedge core_clk) begin
    line_q <= line_n;
    gate_q <= gate;
    if (gate && line_n && !line_q)
      ticks <= ticks + 16'h1;
    if (!gate)
      ticks <= '0;
    if (gate_q && !gate && eq.size() != 0)
      chk_pin("exposure lines", eq.pop_front(), ticks);
    if (bvalid && bready && bq.size() != 0)
      chk_bus("bresp", 34'(bq.pop_front()), 34'(bresp));
    if (rvalid && rready && rq.size() != 0)
      chk_bus("rdata", rq.pop_front(), {rresp, rdata});
    if (smode == 0)
      chk_pin("strobe fixed", 16'h1, 16'(strobe));
    if (smode == 1)
      chk_pin("strobe timing", 16'(gate), 16'(strobe));
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit aw_done;
    bit w_done;
    @(posedge core_clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    @(posedge core_clk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // pulses start mid-line so sync delay never straddles a line edge
  task automatic fire(input bit lk, input logic [5:0] n);
    while (lc != 12) @(posedge core_clk);
    use_link <= lk;
    lines <= n;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : fire

  task automatic settle();
    while (eq.size() != 0) @(posedge core_clk);
    repeat (rd_dly + 8) @(posedge core_clk);
  endtask : settle

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [15:0] n;
    logic [5:0]  w;
    void'($urandom(32'h5ddac303));
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    smode = 0;
    chk_pin("gate at reset", 16'h1, 16'(gate));
    rd(ADDR_CONFIG, 34'h0);
    rd(ADDR_SHUTTER, {RESP_OKAY, 32'h0000_0100});
    rd(4'hc, {RESP_SLVERR, 32'h0});
    wr(4'hc, 32'hffff_ffff, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
    wr(ADDR_CONFIG, 32'h61, RESP_OKAY);
    rd(ADDR_CONFIG, {RESP_OKAY, 32'h61});
    // only byte lane 1 enabled: lane 0 must keep its select bits
    wstrb <= 4'h2;
    wr(ADDR_CONFIG, 32'h0000_ab00, RESP_OKAY);
    wstrb <= 4'hf;
    rd(ADDR_CONFIG, {RESP_OKAY, 32'h0000_ab61});
    fire(0, 6'd2);
    repeat (3 * LINE) @(posedge core_clk);
    chk_pin("gate no shutter", 16'h1, 16'(gate));
    end_test("reset and registers");
    smode = 2;
    for (int i = 0; i < 2; i++) begin
      n = 16'($urandom_range(8, 1));
      wr(ADDR_SHUTTER, {8'h0, n, 4'h0, i ? 4'h5 : 4'h9}, RESP_OKAY);
      wr(ADDR_CONFIG, i ? 32'h23 : 32'h21, RESP_OKAY);
      // let the strobe register pick up the new select before watching it
      @(posedge core_clk);
      smode = 1;
      eq.push_back(n);
      fire(0, 6'($urandom_range(4, 1)));
      settle();
      smode = 2;
    end
    end_test("preset shutter");
    wr(ADDR_SHUTTER, {8'h0, 16'h3, 4'h0, SHUT_PWC_POS}, RESP_OKAY);
    smode = 1;
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 6'd1 : 6'($urandom_range(6, 2));
      eq.push_back(16'(w));
      fire(0, w);
      settle();
      rd(ADDR_STATUS, {RESP_OKAY, 10'h0, w, 16'h0});
    end
    end_test("pulse width");
    smode = 2;
    wr(ADDR_CONFIG, 32'h24, RESP_OKAY);
    inv <= 1'b1;
    n = 16'($urandom_range(8, 1));
    wr(ADDR_SHUTTER, {8'h0, n, 8'h2}, RESP_OKAY);
    wr(ADDR_CONFIG, 32'h25, RESP_OKAY);
    smode = 1;
    for (int i = 0; i < 2; i++) begin
      eq.push_back(n);
      fire(i == 0, 6'd1);
      settle();
    end
    end_test("link polarity");
    smode = 2;
    wr(ADDR_CONFIG, 32'h45, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk_pin("busy idle", 16'h0, 16'(strobe));
    rd_dly = 6 * LINE;
    eq.push_back(n);
    fire(0, 6'd1);
    while (eq.size() != 0) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    chk_pin("busy after exposure", 16'h1, 16'(strobe));
    fire(0, 6'd1);
    repeat (3 * LINE) @(posedge core_clk);
    chk_pin("gate while busy", 16'h0, 16'(gate));
    repeat (4 * LINE) @(posedge core_clk);
    chk_pin("busy after readout", 16'h0, 16'(strobe));
    rd_dly = 4;
    end_test("busy output");
    wr(ADDR_CONFIG, 32'h24, RESP_OKAY);
    @(posedge core_clk);
    smode = 1;
    eq.push_back(n);
    while (lc != 12) @(posedge core_clk);
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    settle();
    end_test("continuous strobe");
    wrap_up();
  end
endmodule : ets_ctrl_tb
